/* rtl/watchdog_with_reset_cause.sv */
// Behaviour
// - Two-bit counter steps on selected carries
// - Selector picks prescaler or watch carry
// - Select bit 0 watch, 1 prescaler
// - Prescaler source in sub-clock stops counting
// - Overflow raises internal reset request
// - First zero write starts, latches interval
// - Later zero writes clear the counter
// - Writing one changes nothing
// - Prescaler intervals from four taps
// - Watch timer intervals from four taps
// - Prescaler interval scales by tap
// - Interval writes ignored once running
// - Stops on power-on, standby exit, overflow
// - External or software reset clears only
// - Low-power entry clears the counter
// - Counter held at zero during low-power mode
// - Timer clears delay the next step
// - Each reset sets its cause flag
// - Other flags keep value except power-on
// - Reading the register clears cause flags
`timescale 1ns/100ps
`default_nettype none
`include "wdt_regs.svh"

module watchdog_with_reset_cause (
	input  wire logic        clock,
	input  wire logic        rst_n,
	// Avalon-MM slave
	input  wire logic [7:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [3:0]  byteenable,
	input  wire logic [31:0] writedata,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	// Count carries from the timers
	input  wire logic [3:0]  prescaler_carry,
	input  wire logic [3:0]  watch_carry,
	input  wire logic        count_source_select_bit,
	// Clock mode and low-power state
	input  wire logic        sub_clock_mode,
	input  wire logic        low_power_mode,
	// Chip reset events, one cycle each
	input  wire logic        standby_exit_reset,
	input  wire logic        external_pin_reset,
	input  wire logic        software_reset,
	// Reset request to the chip reset logic
	output logic             reset_request
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	wdt_pkg::watchdog_state_t q;
	wdt_pkg::watchdog_state_t next_q;

	logic       tick;
	logic [4:0] cause_flags;
	logic [4:0] cause_set;
	logic       cause_clear;
	logic       bus_take;
	logic       hit;
	logic       write_hit;
	logic       read_hit;
	logic       refresh_write;
	logic       overflow;
	logic       count_clear;

	// ------------------------------------------------------------------
	// Count source
	// ------------------------------------------------------------------
	wdt_carry_select u_carry_select (
		.clock           (clock),
		.rst_n           (rst_n),
		.source_select   (count_source_select_bit),
		.sub_clock_mode  (sub_clock_mode),
		.interval        (q.interval),
		.prescaler_carry (prescaler_carry),
		.watch_carry     (watch_carry),
		.tick            (tick)
	);

	// ------------------------------------------------------------------
	// Reset cause flags
	// ------------------------------------------------------------------
	wdt_cause_capture u_cause_capture (
		.clock (clock),
		.rst_n (rst_n),
		.set   (cause_set),
		.clear (cause_clear),
		.flags (cause_flags)
	);

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	always_comb begin
		bus_take  = (read | write) & ~q.waitrequest;
		hit       = (address == `WDT_CTRL_ADDR);
		write_hit = bus_take & write & hit & byteenable[`WDT_LANE0];
		read_hit  = bus_take & read & hit & byteenable[`WDT_LANE0];
	end

	// Only a zero on the enable bit acts; a one is ignored
	assign refresh_write = write_hit & ~writedata[`WDT_ENABLE_BIT];

	// Read clears the cause field as a side effect
	assign cause_clear = read_hit;

	// ------------------------------------------------------------------
	// Counter clear and overflow events
	// ------------------------------------------------------------------
	always_comb begin
		count_clear = external_pin_reset | software_reset;
		count_clear = count_clear | low_power_mode;
		count_clear = count_clear | refresh_write;
	end

	// Overflow on the step that would wrap three to zero
	assign overflow = (q.state == wdt_pkg::WDT_RUN)
		& ~standby_exit_reset
		& ~count_clear
		& tick
		& (q.count == `WDT_COUNT_MAX);

	// ------------------------------------------------------------------
	// Cause events
	// ------------------------------------------------------------------
	always_comb begin
		cause_set = `WDT_CAUSE_NONE;
		cause_set[`WDT_CAUSE_STANDBY]  = standby_exit_reset;
		cause_set[`WDT_CAUSE_OVERFLOW] = overflow;
		cause_set[`WDT_CAUSE_EXTERNAL] = external_pin_reset;
		cause_set[`WDT_CAUSE_SOFTWARE] = software_reset;
	end

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		next_q = q;
		next_q.reset_request = 1'b0;

		// Bus handshake: one wait cycle, then one answer cycle
		if ((read | write) & q.waitrequest) begin
			next_q.waitrequest = 1'b0;
		end else begin
			next_q.waitrequest = `WDT_WAIT_RESET;
		end

		// Read data, write-only bits return zero
		next_q.readdata = `WDT_DATA_RESET;
		// Causes landing at the end of the wait cycle are reported; those at the taking edge stay set
		if ((read & q.waitrequest) & hit & byteenable[`WDT_LANE0]) begin
			next_q.readdata[`WDT_CAUSE_MSB:`WDT_CAUSE_LSB] = cause_flags | cause_set;
		end

		case (q.state)
			wdt_pkg::WDT_IDLE: begin
				next_q.count = `WDT_COUNT_RESET;
				if (refresh_write) begin
					next_q.state    = wdt_pkg::WDT_RUN;
					next_q.interval = writedata[`WDT_INTERVAL_MSB:`WDT_INTERVAL_LSB];
				end
			end
			wdt_pkg::WDT_RUN: begin
				// Interval stays frozen while running
				if (standby_exit_reset) begin
					next_q.state = wdt_pkg::WDT_IDLE;
					next_q.count = `WDT_COUNT_RESET;
				end else if (count_clear) begin
					next_q.count = `WDT_COUNT_RESET;
				end else if (tick) begin
					if (overflow) begin
						next_q.state         = wdt_pkg::WDT_FIRE;
						next_q.count         = `WDT_COUNT_RESET;
						next_q.reset_request = 1'b1;
					end else begin
						next_q.count = q.count + `WDT_COUNT_STEP;
					end
				end
			end
			wdt_pkg::WDT_FIRE: begin
				// Own overflow reset stops the watchdog
				next_q.state = wdt_pkg::WDT_IDLE;
				next_q.count = `WDT_COUNT_RESET;
			end
			default: begin
				next_q.state = wdt_pkg::WDT_IDLE;
				next_q.count = `WDT_COUNT_RESET;
			end
		endcase
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			q.state         <= wdt_pkg::WDT_IDLE;
			q.count         <= `WDT_COUNT_RESET;
			q.interval      <= `WDT_INTERVAL_RESET;
			q.waitrequest   <= `WDT_WAIT_RESET;
			q.readdata      <= `WDT_DATA_RESET;
			q.reset_request <= 1'b0;
		end else begin
			q <= next_q;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign readdata      = q.readdata;
	assign waitrequest   = q.waitrequest;
	assign reset_request = q.reset_request;

endmodule : watchdog_with_reset_cause
`default_nettype wire

/* rtl/wdt_regs.svh */
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define WDT_CTRL_ADDR      8'ha8
`define WDT_ENABLE_BIT     2
`define WDT_INTERVAL_MSB   1
`define WDT_INTERVAL_LSB   0
`define WDT_CAUSE_MSB      7
`define WDT_CAUSE_LSB      3
`define WDT_LANE0          0

// ----------------------------------------------------------------------
// Cause flag positions inside the five-bit cause field
// ----------------------------------------------------------------------
`define WDT_CAUSE_POWER_ON 4
`define WDT_CAUSE_STANDBY  3
`define WDT_CAUSE_OVERFLOW 2
`define WDT_CAUSE_EXTERNAL 1
`define WDT_CAUSE_SOFTWARE 0

// ----------------------------------------------------------------------
// Reset and limit values
// ----------------------------------------------------------------------
`define WDT_CAUSE_RESET    5'h10
`define WDT_CAUSE_NONE     5'h00
`define WDT_COUNT_RESET    2'h0
`define WDT_COUNT_MAX      2'h3
`define WDT_COUNT_STEP     2'h1
`define WDT_INTERVAL_RESET 2'h0
`define WDT_DATA_RESET     32'h0000_0000
`define WDT_WAIT_RESET     1'b1
`define WDT_SRC_WATCH      1'b0
`define WDT_SRC_PRESCALER  1'b1

`endif

/* rtl/wdt_pkg.sv */
package wdt_pkg;

	// ------------------------------------------------------------------
	// Activation states, Gray along idle, run, fire
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		WDT_IDLE = 2'h0,
		WDT_RUN  = 2'h1,
		WDT_FIRE = 2'h3
	} wdt_state_t;

	typedef struct packed {
		wdt_state_t  state;
		logic [1:0]  count;
		logic [1:0]  interval;
		logic        waitrequest;
		logic [31:0] readdata;
		logic        reset_request;
	} watchdog_state_t;

	typedef struct packed {
		logic tick;
	} carry_state_t;

	typedef struct packed {
		logic [4:0] flags;
	} cause_state_t;

endpackage : wdt_pkg

/* rtl/wdt_carry_select.sv */
`timescale 1ns/100ps
`default_nettype none
`include "wdt_regs.svh"

module wdt_carry_select (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       source_select,
	input  wire logic       sub_clock_mode,
	input  wire logic [1:0] interval,
	input  wire logic [3:0] prescaler_carry,
	input  wire logic [3:0] watch_carry,
	output logic            tick
);

	wdt_pkg::carry_state_t q;
	wdt_pkg::carry_state_t next_q;

	// ------------------------------------------------------------------
	// Source and tap selection
	// ------------------------------------------------------------------
	always_comb begin
		next_q = q;
		if (source_select == `WDT_SRC_PRESCALER) begin
			next_q.tick = prescaler_carry[interval] & ~sub_clock_mode;
		end else begin
			next_q.tick = watch_carry[interval];
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			q.tick <= 1'b0;
		end else begin
			q <= next_q;
		end
	end

	assign tick = q.tick;

endmodule : wdt_carry_select
`default_nettype wire

/* rtl/wdt_cause_capture.sv */
`timescale 1ns/100ps
`default_nettype none
`include "wdt_regs.svh"

module wdt_cause_capture (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic [4:0] set,
	input  wire logic       clear,
	output logic      [4:0] flags
);

	wdt_pkg::cause_state_t q;
	wdt_pkg::cause_state_t next_q;

	// ------------------------------------------------------------------
	// Sticky flags, set wins over read clear
	// ------------------------------------------------------------------
	always_comb begin
		next_q = q;
		if (clear) begin
			next_q.flags = `WDT_CAUSE_NONE;
		end
		next_q.flags = next_q.flags | set;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			q.flags <= `WDT_CAUSE_RESET;
		end else begin
			q <= next_q;
		end
	end

	assign flags = q.flags;

endmodule : wdt_cause_capture
`default_nettype wire

/* bench/wdt_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module wdt_monitor (
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	input wire logic [3:0]  prescaler_carry,
	input wire logic [3:0]  watch_carry,
	input wire logic        count_source_select_bit,
	input wire logic        sub_clock_mode,
	input wire logic        low_power_mode,
	input wire logic        external_pin_reset,
	input wire logic        software_reset,
	input wire logic        reset_request
);
	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	AST_WAIT_ANSWER: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("access not answered next cycle");
	AST_WAIT_PULSE: assert property (!waitrequest |=> waitrequest)
		else $error("answer longer than one cycle");
	AST_READ_IDLE: assert property (waitrequest |-> readdata == 32'h0)
		else $error("read data outside answer");
	AST_WRITE_ONLY_BITS: assert property (!waitrequest |-> readdata[2:0] == 3'h0)
		else $error("write-only bits not zero");
	AST_RESET_PULSE: assert property (reset_request |=> !reset_request)
		else $error("reset request longer than one cycle");
	AST_LOW_POWER: assert property (low_power_mode |=> !reset_request)
		else $error("overflow in low-power mode");
	AST_SUB_STOP: assert property
		((sub_clock_mode && count_source_select_bit) [*3] |-> !reset_request)
		else $error("count in sub-clock mode with prescaler");
	AST_NEEDS_CARRY: assert property
		((prescaler_carry == 4'h0 && watch_carry == 4'h0) [*3] |-> !reset_request)
		else $error("overflow without carry");
	AST_CLEAR_DELAY: assert property
		((external_pin_reset || software_reset) |-> ##2 !reset_request [*3])
		else $error("overflow too soon after clear");
endmodule : wdt_monitor
`default_nettype wire

/* bench/watchdog_with_reset_cause_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module watchdog_with_reset_cause_tb_top;
	logic        clock;
	logic        rst_n;
	logic [7:0]  address;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic        waitrequest;
	logic [3:0]  prescaler_carry;
	logic [3:0]  watch_carry;
	logic        count_source_select_bit;
	logic        sub_clock_mode;
	logic        low_power_mode;
	logic [2:0]  cause;
	logic        reset_request;
	logic [31:0] fires;
	logic [31:0] q;
	int          fails;
	int          comparisons;

	watchdog_with_reset_cause dut (
		.clock(clock), .rst_n(rst_n), .address(address), .read(read), .write(write),
		.byteenable(4'h1), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .prescaler_carry(prescaler_carry),
		.watch_carry(watch_carry), .count_source_select_bit(count_source_select_bit),
		.sub_clock_mode(sub_clock_mode), .low_power_mode(low_power_mode),
		.standby_exit_reset(cause[2]), .external_pin_reset(cause[1]),
		.software_reset(cause[0]), .reset_request(reset_request)
	);

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	always @(posedge clock) begin
		if (!rst_n)
			fires <= 32'h0;
		else if (reset_request === 1'b1)
			fires <= fires + 32'h1;
	end

	task automatic print_verdict;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : print_verdict

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic bus(input logic rd, input logic [7:0] a, input logic [7:0] d);
		int n;
		@(posedge clock);
		read      <= rd;
		write     <= !rd;
		address   <= a;
		writedata <= {24'h0, d};
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (waitrequest !== 1'b0 && n < 20);
		q = readdata;
		read  <= 1'b0;
		write <= 1'b0;
		if (n >= 20) begin
			fails++;
			print_verdict();
		end
	endtask : bus

	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		bus(1'b1, a, 8'h00);
		chk("readdata", {24'h0, e}, q);
	endtask : rdc

	task automatic pulse(input logic w, input logic [1:0] t, input int n);
		repeat (n) begin
			@(posedge clock);
			if (w)
				watch_carry <= 4'h1 << t;
			else
				prescaler_carry <= 4'h1 << t;
			@(posedge clock);
			watch_carry     <= 4'h0;
			prescaler_carry <= 4'h0;
			repeat (2) @(posedge clock);
		end
	endtask : pulse

	task automatic ev(input logic [2:0] c);
		@(posedge clock);
		cause <= c;
		@(posedge clock);
		cause <= 3'h0;
		repeat (2) @(posedge clock);
	endtask : ev

	task automatic fc(input logic [31:0] e);
		repeat (3) @(posedge clock);
		chk("overflow count", e, fires);
	endtask : fc

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		{read, write, address, writedata, fails, comparisons} = '0;
		{prescaler_carry, watch_carry, sub_clock_mode, low_power_mode, cause} = '0;
		q = '0;
		count_source_select_bit = 1'b1;
		rst_n = 1'b0;
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		rdc(8'ha8, 8'h80);
		chk("power_on_cause_flag", 32'h1, {31'h0, q[7]});
		rdc(8'ha8, 8'h00);
		bus(1'b0, 8'ha9, 8'h00);
		rdc(8'ha9, 8'h00);
		pulse(1'b0, 2'h0, 6);
		fc(32'h0);
		bus(1'b0, 8'ha8, 8'h04);
		pulse(1'b0, 2'h0, 6);
		fc(32'h0);
		bus(1'b0, 8'ha8, 8'h01);
		bus(1'b0, 8'ha8, 8'h03);
		pulse(1'b0, 2'h0, 6);
		pulse(1'b1, 2'h1, 6);
		fc(32'h0);
		pulse(1'b0, 2'h1, 3);
		bus(1'b0, 8'ha8, 8'h00);
		pulse(1'b0, 2'h1, 3);
		fc(32'h0);
		bus(1'b0, 8'ha8, 8'h04);
		pulse(1'b0, 2'h1, 1);
		fc(32'h1);
		rdc(8'ha8, 8'h20);
		pulse(1'b0, 2'h1, 6);
		fc(32'h1);
		count_source_select_bit <= 1'b0;
		bus(1'b0, 8'ha8, 8'h03);
		pulse(1'b1, 2'h3, 3);
		ev(3'h2);
		pulse(1'b1, 2'h3, 3);
		fc(32'h1);
		ev(3'h1);
		pulse(1'b1, 2'h3, 3);
		fc(32'h1);
		low_power_mode <= 1'b1;
		pulse(1'b1, 2'h3, 4);
		low_power_mode <= 1'b0;
		pulse(1'b1, 2'h3, 3);
		fc(32'h1);
		pulse(1'b1, 2'h3, 1);
		fc(32'h2);
		rdc(8'ha8, 8'h38);
		count_source_select_bit <= 1'b1;
		sub_clock_mode          <= 1'b1;
		bus(1'b0, 8'ha8, 8'h00);
		pulse(1'b0, 2'h0, 6);
		fc(32'h2);
		sub_clock_mode <= 1'b0;
		pulse(1'b0, 2'h0, 4);
		fc(32'h3);
		bus(1'b0, 8'ha8, 8'h00);
		ev(3'h4);
		pulse(1'b0, 2'h0, 6);
		fc(32'h3);
		bus(1'b0, 8'ha8, 8'h02);
		pulse(1'b0, 2'h1, 4);
		fc(32'h3);
		pulse(1'b0, 2'h2, 4);
		fc(32'h4);
		rdc(8'ha8, 8'h60);
		print_verdict();
	end
endmodule : watchdog_with_reset_cause_tb_top

bind watchdog_with_reset_cause wdt_monitor u_monitor (
	.clock(clock), .rst_n(rst_n), .read(read), .write(write), .readdata(readdata),
	.waitrequest(waitrequest), .prescaler_carry(prescaler_carry),
	.watch_carry(watch_carry), .count_source_select_bit(count_source_select_bit),
	.sub_clock_mode(sub_clock_mode), .low_power_mode(low_power_mode),
	.external_pin_reset(external_pin_reset), .software_reset(software_reset),
	.reset_request(reset_request)
);
`default_nettype wire
